// ===== emt_mem_model.sv
`timescale 1ns/1ps
module emt_mem_model (
   input wire logic clock_in,
   input wire logic [15:0] addr_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic data_oe_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [0:255];
   logic [7:0] last_q = 8'h00;
   always @(posedge clock_in) begin
      if (!wr_n_in && data_oe_in) begin
         mem[addr_in[7:0]] <= wdata_in;
      end
      if (!rd_n_in) begin
         last_q <= rdata_out;
      end
   end
   // released bus shows the inverse of the last value, never a stale copy
   always_comb begin
      if (!rd_n_in) begin
         rdata_out = mem[addr_in[7:0]];
      end else begin
         rdata_out = ~last_q;
      end
   end
endmodule

// ===== emt_pkg.sv
// Function
// - address and control lead the strobe by 0 to 3 cycles after any latch phase, field bits 7:6
// - strobe stays asserted for field bits 5:2 plus one cycles, 1 to 16
// - address and control stay valid 0 to 3 cycles after strobe, bits 1:0
// - every non-multiplexed access lasts setup plus width plus hold plus four cycles
// - shortest non-multiplexed access is five cycles
// - multiplexed latch phase adds at least two cycles, shortest access seven
// - timing register resets to all ones, slowest setup and hold
// - latch strobe high and low times each 1 to 4 cycles from two-bit field
// - write data leads strobe trailing edge by 1 to 19 cycles
// - write data held after strobe for the programmed hold, 0 to 3 cycles
package emt_pkg;
   localparam logic [7:0] EMT_TC_ADDR = 8'h84;
   localparam logic [7:0] EMT_TC_RESET = 8'hff;
   localparam int EMT_SETUP_LSB = 6;
   localparam int EMT_WIDTH_LSB = 2;
   localparam int EMT_HOLD_LSB = 0;
   localparam logic [3:0] EMT_OVH_CYCLES = 4'h4;
   localparam int EMT_CLK_MHZ = 50;
   localparam int EMT_CLK_PERIOD_NS = 1000 / EMT_CLK_MHZ;

   typedef struct packed {
      logic [1:0] addr_setup_select;
      logic [3:0] strobe_width_select;
      logic [1:0] addr_hold_select;
   } emt_timing_s;

   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } emt_req_s;

   typedef enum logic [2:0] {
      EMT_IDLE = 3'b000,
      EMT_ALE_HI = 3'b001,
      EMT_ALE_LO = 3'b010,
      EMT_SETUP = 3'b011,
      EMT_STROBE = 3'b100,
      EMT_HOLD = 3'b101,
      EMT_OVH = 3'b110
   } emt_state_e;
endpackage

// ===== emt_timing.sv
`timescale 1ns/1ps
module emt_timing (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] sfr_rdata_out,
   input wire logic mux_mode_in,
   input wire logic [1:0] ale_width_in,
   input wire logic req_valid_in,
   input wire emt_pkg::emt_req_s req_in,
   output logic req_ready_out,
   output logic done_out,
   output logic [7:0] rdata_out,
   output logic [15:0] addr_out,
   output logic bus_active_out,
   output logic ale_out,
   output logic rd_n_out,
   output logic wr_n_out,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe_out
);
   ////////////////////////////////////////////////////////////////////
   emt_pkg::emt_timing_s tc_q, tc_d, cfg_q, cfg_d;
   emt_pkg::emt_req_s acc_q, acc_d;
   emt_pkg::emt_state_e state_q, state_d;
   logic [3:0] cnt_q, cnt_d;
   logic mux_q, mux_d;
   logic [1:0] alew_q, alew_d;
   logic [7:0] sfr_rdata_q, sfr_rdata_d, rdata_q, rdata_d;
   logic ale_q, ale_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, oe_q, oe_d, act_q, act_d;

   // length of a setup or hold phase as a down-count load, zero length skipped
   function automatic logic [3:0] emt_load(input logic [1:0] n);
      emt_load = {2'h0, n} - 4'h1;
   endfunction

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      tc_d = tc_q;
      if (sfr_wr_in && sfr_addr_in == emt_pkg::EMT_TC_ADDR) begin
         tc_d = emt_pkg::emt_timing_s'(sfr_wdata_in);
      end
      sfr_rdata_d = (sfr_addr_in == emt_pkg::EMT_TC_ADDR) ? tc_q : 8'h00;
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tc_q <= emt_pkg::EMT_TC_RESET;
         sfr_rdata_q <= 8'h00;
      end else begin
         tc_q <= tc_d;
         sfr_rdata_q <= sfr_rdata_d;
      end
   end

   assign sfr_rdata_out = sfr_rdata_q;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      cfg_d = cfg_q;
      acc_d = acc_q;
      mux_d = mux_q;
      alew_d = alew_q;
      rdata_d = rdata_q;
      case (state_q)
         emt_pkg::EMT_IDLE: begin
            if (req_valid_in) begin
               cfg_d = tc_q;
               acc_d = req_in;
               mux_d = mux_mode_in;
               alew_d = ale_width_in;
               if (mux_mode_in) begin
                  state_d = emt_pkg::EMT_ALE_HI;
                  cnt_d = {2'h0, ale_width_in};
               end else if (tc_q.addr_setup_select != 2'h0) begin
                  state_d = emt_pkg::EMT_SETUP;
                  cnt_d = emt_load(tc_q.addr_setup_select);
               end else begin
                  state_d = emt_pkg::EMT_STROBE;
                  cnt_d = tc_q.strobe_width_select;
               end
            end
         end
         emt_pkg::EMT_ALE_HI: begin
            if (cnt_q == 4'h0) begin
               state_d = emt_pkg::EMT_ALE_LO;
               cnt_d = {2'h0, alew_q};
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         emt_pkg::EMT_ALE_LO: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (cfg_q.addr_setup_select != 2'h0) begin
               state_d = emt_pkg::EMT_SETUP;
               cnt_d = emt_load(cfg_q.addr_setup_select);
            end else begin
               state_d = emt_pkg::EMT_STROBE;
               cnt_d = cfg_q.strobe_width_select;
            end
         end
         emt_pkg::EMT_SETUP: begin
            if (cnt_q == 4'h0) begin
               state_d = emt_pkg::EMT_STROBE;
               cnt_d = cfg_q.strobe_width_select;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         emt_pkg::EMT_STROBE: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               if (!acc_q.write) begin
                  rdata_d = data_in;
               end
               if (cfg_q.addr_hold_select != 2'h0) begin
                  state_d = emt_pkg::EMT_HOLD;
                  cnt_d = emt_load(cfg_q.addr_hold_select);
               end else begin
                  state_d = emt_pkg::EMT_OVH;
                  cnt_d = emt_pkg::EMT_OVH_CYCLES - 4'h1;
               end
            end
         end
         emt_pkg::EMT_HOLD: begin
            if (cnt_q == 4'h0) begin
               state_d = emt_pkg::EMT_OVH;
               cnt_d = emt_pkg::EMT_OVH_CYCLES - 4'h1;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         emt_pkg::EMT_OVH: begin
            if (cnt_q == 4'h0) begin
               state_d = emt_pkg::EMT_IDLE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: begin
            state_d = emt_pkg::EMT_IDLE;
            cnt_d = 4'h0;
         end
      endcase
      // pins follow the next state so they change on the same edge as it
      ale_d = (state_d == emt_pkg::EMT_ALE_HI);
      rd_n_d = !(state_d == emt_pkg::EMT_STROBE && !acc_d.write);
      wr_n_d = !(state_d == emt_pkg::EMT_STROBE && acc_d.write);
      act_d = (state_d != emt_pkg::EMT_IDLE) && (state_d != emt_pkg::EMT_OVH);
      oe_d = acc_d.write && (state_d == emt_pkg::EMT_SETUP || state_d == emt_pkg::EMT_STROBE ||
                             state_d == emt_pkg::EMT_HOLD);
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= emt_pkg::EMT_IDLE;
         cnt_q <= 4'h0;
         cfg_q <= emt_pkg::EMT_TC_RESET;
         acc_q <= '0;
         mux_q <= 1'b0;
         alew_q <= 2'h0;
         rdata_q <= 8'h00;
         ale_q <= 1'b0;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         oe_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cfg_q <= cfg_d;
         acc_q <= acc_d;
         mux_q <= mux_d;
         alew_q <= alew_d;
         rdata_q <= rdata_d;
         ale_q <= ale_d;
         rd_n_q <= rd_n_d;
         wr_n_q <= wr_n_d;
         oe_q <= oe_d;
         act_q <= act_d;
      end
   end

   assign req_ready_out = (state_q == emt_pkg::EMT_IDLE);
   assign done_out = (state_q == emt_pkg::EMT_OVH) && (cnt_q == 4'h0);
   assign rdata_out = rdata_q;
   assign addr_out = acc_q.addr;
   assign data_out = acc_q.wdata;
   assign data_oe_out = oe_q;
   assign ale_out = ale_q;
   assign rd_n_out = rd_n_q;
   assign wr_n_out = wr_n_q;
   assign bus_active_out = act_q;

   ////////////////////////////////////////////////////////////////////
   logic [5:0] acc_cnt_q, acc_cnt_d, t_on_q, t_on_d, t_off_q, t_off_d, ale_cyc;
   logic strb_n, first_q;
   assign strb_n = rd_n_q && wr_n_q;
   assign ale_cyc = mux_q ? {3'h0, alew_q, 1'b0} + 6'h2 : 6'h0;

   // strobe length counted cycle by cycle, so a strobe in the first access cycle measures right
   always_comb begin
      acc_cnt_d = (state_q == emt_pkg::EMT_IDLE) ? 6'h0 : acc_cnt_q + 6'h1;
      t_on_d = t_on_q;
      t_off_d = t_off_q;
      if (state_q == emt_pkg::EMT_IDLE) begin
         t_on_d = 6'h0;
      end else if (!strb_n) begin
         t_on_d = t_on_q + 6'h1;
      end
      if (!strb_n) begin
         t_off_d = acc_cnt_q + 6'h1;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_cnt_q <= 6'h0;
         t_on_q <= 6'h0;
         t_off_q <= 6'h0;
         first_q <= 1'b1;
      end else begin
         acc_cnt_q <= acc_cnt_d;
         t_on_q <= t_on_d;
         t_off_q <= t_off_d;
         first_q <= 1'b0;
      end
   end

   sequence emt_strobe_starts;
      !strb_n && $past(strb_n);
   endsequence

   sequence emt_strobe_ends;
      strb_n && !$past(strb_n);
   endsequence

   AST_SETUP: assert property (@(posedge clock_in) disable iff (!resetn_in)
      emt_strobe_starts |-> acc_cnt_q == ale_cyc + {4'h0, cfg_q.addr_setup_select})
      else $error("strobe did not follow the programmed setup");
   AST_WIDTH: assert property (@(posedge clock_in) disable iff (!resetn_in)
      emt_strobe_ends |-> t_on_q == {2'h0, cfg_q.strobe_width_select} + 6'h1)
      else $error("strobe width differs from programmed width");
   AST_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $fell(act_q) |-> acc_cnt_q == t_off_q + {4'h0, cfg_q.addr_hold_select})
      else $error("address hold differs from programmed hold");
   AST_TOTAL: assert property (@(posedge clock_in) disable iff (!resetn_in)
      done_out |-> acc_cnt_q + 6'h1 == ale_cyc + {4'h0, cfg_q.addr_setup_select} +
         {2'h0, cfg_q.strobe_width_select} + {4'h0, cfg_q.addr_hold_select} + 6'h5)
      else $error("access length is not setup plus width plus hold plus four");
   AST_MIN_PLAIN: assert property (@(posedge clock_in) disable iff (!resetn_in)
      req_valid_in && req_ready_out && !mux_mode_in |-> ##1 !done_out [*4])
      else $error("plain access shorter than five cycles");
   AST_MIN_MUX: assert property (@(posedge clock_in) disable iff (!resetn_in)
      done_out && mux_q |-> acc_cnt_q >= 6'h6)
      else $error("multiplexed access shorter than seven cycles");
   AST_RESET_VAL: assert property (@(posedge clock_in) disable iff (!resetn_in)
      first_q |-> tc_q == emt_pkg::EMT_TC_RESET)
      else $error("timing register not all ones after reset");
   AST_ALE_HIGH: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $fell(ale_out) |-> acc_cnt_q == {4'h0, alew_q} + 6'h1)
      else $error("latch strobe high time wrong");
   AST_WDATA_LEAD: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $rose(data_oe_out) |-> acc_cnt_q == ale_cyc)
      else $error("write data not driven from setup start");
   AST_WDATA_HOLD: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $fell(data_oe_out) |-> acc_cnt_q == t_off_q + {4'h0, cfg_q.addr_hold_select})
      else $error("write data hold differs from programmed hold");
   AST_RELEASE: assert property (@(posedge clock_in) disable iff (!resetn_in)
      $fell(act_q) |-> !done_out ##3 done_out)
      else $error("completion not four cycles after bus release");
endmodule

// ===== emt_timing_tb_top.sv
`timescale 1ns/1ps
module emt_timing_tb_top;
   logic clock_in = 1'b0;
   logic resetn_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00;
   logic sfr_wr_in = 1'b0;
   logic [7:0] sfr_wdata_in = 8'h00;
   logic [7:0] sfr_rdata_out;
   logic mux_mode_in = 1'b0;
   logic [1:0] ale_width_in = 2'h0;
   logic req_valid_in = 1'b0;
   emt_pkg::emt_req_s req_in = '0;
   logic req_ready_out, done_out, bus_active_out, ale_out, rd_n_out, wr_n_out, data_oe_out;
   logic [7:0] rdata_out, data_in, data_out;
   logic [15:0] addr_out;
   int fails = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'h39;
   always #10 clock_in = ~clock_in;
   emt_timing u_emt_timing (.clock_in(clock_in), .resetn_in(resetn_in), .sfr_addr_in(sfr_addr_in),
      .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
      .mux_mode_in(mux_mode_in), .ale_width_in(ale_width_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .req_ready_out(req_ready_out), .done_out(done_out), .rdata_out(rdata_out),
      .addr_out(addr_out), .bus_active_out(bus_active_out), .ale_out(ale_out), .rd_n_out(rd_n_out),
      .wr_n_out(wr_n_out), .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out));
   emt_mem_model u_emt_mem_model (.clock_in(clock_in), .addr_in(addr_out), .rd_n_in(rd_n_out),
      .wr_n_in(wr_n_out), .data_oe_in(data_oe_out), .wdata_in(data_out), .rdata_out(data_in));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] lead_len(input logic [7:0] tc, input logic mx, input logic [1:0] aw);
      return (mx ? 2 * (aw + 1) : 0) + tc[7:6];
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      @(negedge clock_in);
      sfr_wr_in = 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr_in = a;
      @(negedge clock_in);
      check(sfr_rdata_out, exp);
   endtask
   task automatic run_access(input logic wr, input logic [15:0] a, input logic [7:0] d,
      input logic [7:0] tc, input logic mx, input logic [1:0] aw);
      int tot, pre, stb, post, alec, oec;
      tot = 0;
      pre = 0;
      stb = 0;
      post = 0;
      alec = 0;
      oec = 0;
      mux_mode_in = mx;
      ale_width_in = aw;
      req_in = '{write: wr, addr: a, wdata: d};
      req_valid_in = 1'b1;
      @(negedge clock_in);
      req_valid_in = 1'b0;
      while (tot < 60) begin
         tot++;
         if (rd_n_out === 1'b0 || wr_n_out === 1'b0) stb++;
         else if (bus_active_out === 1'b1 && stb == 0) pre++;
         else if (bus_active_out === 1'b1) post++;
         if (ale_out === 1'b1) alec++;
         if (data_oe_out === 1'b1) oec++;
         if (done_out === 1'b1) break;
         @(negedge clock_in);
      end
      check(tot, lead_len(tc, mx, aw) + tc[5:2] + 1 + tc[1:0] + 4);
      check(pre, lead_len(tc, mx, aw));
      check(stb, tc[5:2] + 1);
      check(post, tc[1:0]);
      check(alec, mx ? aw + 1 : 0);
      check(oec, wr ? tc[7:6] + tc[5:2] + 1 + tc[1:0] : 0);
      check(addr_out, a);
      if (!wr) check(rdata_out, d);
      @(negedge clock_in);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] tc, d;
      logic [15:0] a;
      logic mx;
      logic [1:0] aw;
      repeat (10) @(negedge clock_in);
      resetn_in = 1'b1;
      @(negedge clock_in);
      reg_read(8'h84, 8'hff);
      reg_read(8'h85, 8'h00);
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         tc = (i == 0) ? 8'hff : (i < 3) ? 8'h00 : seed[7:0];
         mx = (i == 2) ? 1'b1 : (i < 2) ? 1'b0 : seed[8];
         aw = (i == 2) ? 2'h0 : seed[10:9];
         a = seed[31:16];
         d = seed[23:16] ^ seed[15:8];
         if (i > 0) reg_write(8'h84, tc);
         if (i > 0) reg_read(8'h84, tc);
         run_access(1'b1, a, d, tc, mx, aw);
         run_access(1'b0, a, d, tc, ~mx, aw);
         $display("test %0d done tc=%h mux=%0d", i, tc, mx);
      end
      reg_write(emt_pkg::EMT_TC_ADDR, 8'h00);
      resetn_in = 1'b0;
      repeat (2) @(negedge clock_in);
      resetn_in = 1'b1;
      @(negedge clock_in);
      reg_read(emt_pkg::EMT_TC_ADDR, emt_pkg::EMT_TC_RESET);
      run_access(1'b0, a, d, emt_pkg::EMT_TC_RESET, 1'b0, aw);
      $display("test mid-run reset done");
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge clock_in);
      fails++;
      tally_and_finish();
   end
endmodule
